// ===== hdl/rsc_reset_source_combiner.sv
// Purpose: merge reset sources, record cause, time master reset release
// Assumes: event inputs are one-cycle pulses sync to i_core_clk
// Notes:   i_nrst is the raw power-on reset of the always-on domain
`timescale 1ns/100ps

module rsc_reset_source_combiner
	import rsc_pkg::*;
#(
	parameter int POR_CYCLES  = POR_CYC,
	parameter int POWER_UP_TIMER_CYCLES = POWER_UP_TIMER_CYC,
	parameter int CLOCK_FAIL_MONITOR_CYCLES = CLOCK_FAIL_MONITOR_CYC,
	parameter int CNT_W       = 23
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_nrst,
	// classic wishbone slave
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [7:0]  i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic      [31:0] o_wb_dat,
	output logic             o_wb_ack,
	// reset and status events
	input  wire logic        i_master_clear_pin,
	input  wire logic        i_brownout_det,
	input  wire logic        i_reset_instr,
	input  wire logic        i_watchdog_reset,
	input  wire logic        i_trap_conflict,
	input  wire logic        i_illegal_op,
	input  wire logic        i_uninit_pointer_reset,
	input  wire logic        i_config_mismatch,
	input  wire logic        i_deep_sleep_wake,
	input  wire logic        i_sleep_instr,
	input  wire logic        i_idle_instr,
	input  wire logic        i_deep_sleep_enable,
	// fuses and clock status
	input  wire logic [1:0]  i_brownout_enable_fuses,
	input  wire logic        i_watchdog_enable_fuse,
	input  wire logic        i_power_up_timer_enable_fuse,
	input  wire logic        i_clk_switch_enable,
	input  wire logic        i_two_speed_enable,
	input  wire logic [2:0]  i_oscillator_fuse_select,
	input  wire logic [2:0]  i_current_oscillator_field,
	input  wire logic        i_osc_is_crystal,
	input  wire logic        i_osc_tick,
	input  wire logic        i_pll_used,
	input  wire logic        i_pll_lock,
	// outputs
	output logic             o_master_system_reset,
	output logic             o_cpu_run,
	output logic [2:0]       o_osc_select,
	output logic             o_clock_fail_monitor_en,
	output logic             o_brownout_en,
	output logic             o_watchdog_en,
	output logic             o_retention_regulator_select,
	output logic             o_progmem_sleep_power
);

	logic [15:0]     cause_ff;
	logic [15:0]     nxt_cause;
	rsc_state_e      st_ff;
	rsc_state_e      nxt_st;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic [10:0]     ost_ff;
	logic [CNT_W-1:0] clock_fail_monitor_ff;
	logic [2:0]      osc_ff;
	logic            rel_ff;
	logic            rel_sync_ff;
	logic            ack_ff;
	logic [31:0]     rdat_ff;
	logic            por_done_ff;

	// synchronous sources; async power-on is i_nrst itself
	wire logic hw_reset = i_master_clear_pin | i_brownout_det | i_reset_instr
		| i_watchdog_reset | i_trap_conflict | i_illegal_op
		| i_uninit_pointer_reset | i_config_mismatch
		| i_deep_sleep_wake;
	wire logic pwr_reset = i_brownout_det | i_deep_sleep_wake;

	// bus decode
	wire logic bus_req  = i_wb_cyc & i_wb_stb & ~ack_ff;
	wire logic wr_cause = bus_req & i_wb_we & (i_wb_adr == RSC_ADDR_CAUSE);
	wire logic [15:0] wmask = {{8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
	wire logic [15:0] wval  = (cause_ff & ~wmask)
		| (i_wb_dat[15:0] & wmask & CAUSE_IMPL);

	// brown-out soft bit only live in fuse mode 01
	wire logic sbor_live = (i_brownout_enable_fuses == BROWNOUT_ENABLE_FUSES_SOFT);
	wire logic [15:0] cause_rd = sbor_live ? cause_ff
		: (cause_ff & ~(16'h0001 << B_SBOR));

	// flag update: software first, hardware sets win over clears
	always_comb begin
		nxt_cause = wr_cause ? wval : cause_ff;
		if (i_sleep_instr | i_idle_instr)
			nxt_cause[B_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
		if (i_trap_conflict)
			nxt_cause[B_TRAP] = 1'b1;
		if (i_illegal_op | i_uninit_pointer_reset)
			nxt_cause[B_IOP] = 1'b1;
		if (i_sleep_instr & i_deep_sleep_enable)
			nxt_cause[B_DSLP] = 1'b1;
		if (i_config_mismatch)
			nxt_cause[B_CM] = 1'b1;
		if (i_master_clear_pin)
			nxt_cause[B_PIN] = 1'b1;
		if (i_reset_instr)
			nxt_cause[B_SWR] = 1'b1;
		if (i_watchdog_reset)
			nxt_cause[B_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
		if (i_sleep_instr)
			nxt_cause[B_SLEEP] = 1'b1;
		if (i_idle_instr)
			nxt_cause[B_IDLE] = 1'b1;
		if (i_brownout_det)
			nxt_cause[B_BOR] = 1'b1;
		if (i_deep_sleep_wake) begin
			nxt_cause[B_BOR] = 1'b1;
			nxt_cause[B_POR] = 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst)
			cause_ff <= CAUSE_POR_VAL;
		else
			cause_ff <= nxt_cause;
	end

	// release sequencer
	wire logic ost_need = i_osc_is_crystal & ~i_two_speed_enable;
	wire logic clk_ok = (~ost_need | ost_ff[10])
		& (~i_pll_used | i_pll_lock);
	wire logic [CNT_W-1:0] power_up_timer_len = i_power_up_timer_enable_fuse
		? CNT_W'(POWER_UP_TIMER_CYCLES) : '0;

	always_comb begin
		nxt_st  = st_ff;
		nxt_cnt = cnt_ff + CNT_W'(1);
		case (st_ff)
		RSC_ST_POR: begin
			if (cnt_ff >= CNT_W'(POR_CYCLES)) begin
				nxt_st  = RSC_ST_POWER_UP_TIMER;
				nxt_cnt = '0;
			end
		end
		RSC_ST_POWER_UP_TIMER: begin
			if (cnt_ff >= power_up_timer_len) begin
				nxt_st  = RSC_ST_RUN;
				nxt_cnt = '0;
			end
		end
		RSC_ST_RUN: begin
			nxt_cnt = '0;
		end
		default: begin
			nxt_st  = RSC_ST_POR;
			nxt_cnt = '0;
		end
		endcase
		if (i_brownout_det | i_deep_sleep_wake) begin
			nxt_st  = RSC_ST_POWER_UP_TIMER;
			nxt_cnt = '0;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_ff  <= RSC_ST_POR;
			cnt_ff <= '0;
		end else begin
			st_ff  <= nxt_st;
			cnt_ff <= nxt_cnt;
		end
	end

	// two-stage release: async assert, clocked release
	wire logic rel_req = (st_ff == RSC_ST_RUN) & ~hw_reset;
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rel_ff      <= 1'b0;
			rel_sync_ff <= 1'b0;
		end else begin
			rel_ff      <= rel_req;
			rel_sync_ff <= rel_ff & rel_req;
		end
	end

	// oscillator start-up count runs during reset delay
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst)
			ost_ff <= '0;
		else if (pwr_reset)
			ost_ff <= '0;
		else if (i_osc_tick & ~ost_ff[10])
			ost_ff <= ost_ff + 11'h001;
	end

	// clock choice on each reset
	wire logic [2:0] osc_pick = i_two_speed_enable ? OSC_FRC
		: i_oscillator_fuse_select;
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst)
			por_done_ff <= 1'b0;
		else
			por_done_ff <= 1'b1;
	end
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst)
			osc_ff <= OSC_FRC;
		else if (!por_done_ff || pwr_reset || !i_clk_switch_enable)
			osc_ff <= osc_pick;
		else if (hw_reset)
			osc_ff <= i_current_oscillator_field;
	end

	// fail monitor delay after release
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst)
			clock_fail_monitor_ff <= '0;
		else if (!rel_sync_ff)
			clock_fail_monitor_ff <= '0;
		else if (clock_fail_monitor_ff < CNT_W'(CLOCK_FAIL_MONITOR_CYCLES))
			clock_fail_monitor_ff <= clock_fail_monitor_ff + CNT_W'(1);
	end

	// wishbone answer: one cycle after request
	wire logic [31:0] rd_mux =
		(i_wb_adr == RSC_ADDR_CAUSE) ? {16'h0000, cause_rd} :
		(i_wb_adr == RSC_ADDR_CLK)   ? {29'h0, osc_ff} :
		(i_wb_adr == RSC_ADDR_STAT)  ? {28'h0, clk_ok, st_ff,
			rel_sync_ff} : 32'h0000_0000;
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ack_ff  <= 1'b0;
			rdat_ff <= 32'h0000_0000;
		end else begin
			ack_ff  <= bus_req;
			rdat_ff <= rd_mux;
		end
	end

	assign o_wb_ack = ack_ff;
	assign o_wb_dat = rdat_ff;
	assign o_master_system_reset = ~rel_sync_ff;
	assign o_cpu_run = rel_sync_ff & clk_ok;
	assign o_osc_select = osc_ff;
	assign o_clock_fail_monitor_en = rel_sync_ff
		& (clock_fail_monitor_ff >= CNT_W'(CLOCK_FAIL_MONITOR_CYCLES));
	assign o_brownout_en = (i_brownout_enable_fuses != 2'h0)
		& (~sbor_live | cause_ff[B_SBOR]);
	assign o_watchdog_en = i_watchdog_enable_fuse
		| cause_ff[B_SWDT];
	assign o_retention_regulator_select = cause_ff[B_RET];
	assign o_progmem_sleep_power = cause_ff[B_PROGMEM_SLEEP_POWER];

endmodule

// ===== shared/rsc_pkg.sv
// Purpose: constants for the reset source combiner
// Assumes: 100 MHz core clock, 32-bit classic Wishbone register bus
// Notes:   one register word holds the 16-bit cause and control field
package rsc_pkg;

	localparam int CLK_MHZ = 100;

	// register map (byte addresses)
	localparam logic [7:0] RSC_ADDR_CAUSE = 8'h00;
	localparam logic [7:0] RSC_ADDR_CLK   = 8'h04;
	localparam logic [7:0] RSC_ADDR_STAT  = 8'h08;

	// cause and control field positions
	localparam int B_TRAP  = 15;
	localparam int B_IOP   = 14;
	localparam int B_SBOR  = 13;
	localparam int B_RET   = 12;
	localparam int B_DSLP  = 10;
	localparam int B_CM    = 9;
	localparam int B_PROGMEM_SLEEP_POWER = 8;
	localparam int B_PIN   = 7;
	localparam int B_SWR   = 6;
	localparam int B_SWDT  = 5;
	localparam int B_WATCHDOG_TIMEOUT_FLAG  = 4;
	localparam int B_SLEEP = 3;
	localparam int B_IDLE  = 2;
	localparam int B_BOR   = 1;
	localparam int B_POR   = 0;

	localparam logic [15:0] CAUSE_POR_VAL  = 16'h0003;
	localparam logic [15:0] CAUSE_IMPL     = 16'hF7FF;
	localparam logic [1:0]  BROWNOUT_ENABLE_FUSES_SOFT     = 2'h1;

	// delays
	localparam int POR_DELAY_US  = 100;
	localparam int POWER_UP_TIMER_DELAY_MS = 64;
	localparam int CLOCK_FAIL_MONITOR_DELAY_US = 2;
	localparam int POR_CYC  = POR_DELAY_US * CLK_MHZ;
	localparam int POWER_UP_TIMER_CYC = POWER_UP_TIMER_DELAY_MS * 1000 * CLK_MHZ;
	localparam int CLOCK_FAIL_MONITOR_CYC = CLOCK_FAIL_MONITOR_DELAY_US * CLK_MHZ;
	localparam int OST_PERIODS = 1024;

	// oscillator select codes
	localparam logic [2:0] OSC_FRC = 3'h0;

	typedef enum logic [1:0] {
		RSC_ST_POR  = 2'b00,
		RSC_ST_POWER_UP_TIMER = 2'b01,
		RSC_ST_RUN  = 2'b11
	} rsc_state_e;

endpackage

// ===== verif/rsc_checker.sv
// Purpose: port-level checks of the reset source combiner
// Assumes: single core clock domain
// Notes:   bound to the design below
`timescale 1ns/100ps

module rsc_checker (
	input wire logic        i_core_clk,
	input wire logic        i_nrst,
	input wire logic        i_wb_cyc,
	input wire logic        i_wb_stb,
	input wire logic        i_wb_we,
	input wire logic [7:0]  i_wb_adr,
	input wire logic [31:0] o_wb_dat,
	input wire logic        o_wb_ack,
	input wire logic        i_master_clear_pin,
	input wire logic [1:0]  i_brownout_enable_fuses,
	input wire logic        i_watchdog_enable_fuse,
	input wire logic        i_clk_switch_enable,
	input wire logic [2:0]  i_current_oscillator_field,
	input wire logic [2:0]  o_osc_select,
	input wire logic        o_master_system_reset,
	input wire logic        o_cpu_run,
	input wire logic        o_clock_fail_monitor_en,
	input wire logic        o_watchdog_en
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);

	sequence req_s;
		i_wb_cyc && i_wb_stb && !o_wb_ack;
	endsequence
	sequence rd0_s;
		o_wb_ack && !i_wb_we && i_wb_adr == 8'h00;
	endsequence

	ack_resp_a: assert property (req_s |=> o_wb_ack)
		else $error("no ack one cycle after request");
	ack_once_a: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack longer than one cycle");
	src_reset_a: assert property (
		i_master_clear_pin |-> ##[1:3] o_master_system_reset)
		else $error("pin source did not assert reset");
	run_gate_a: assert property (
		o_cpu_run |-> !o_master_system_reset)
		else $error("run while master reset active");
	clock_fail_monitor_gate_a: assert property (
		o_clock_fail_monitor_en |-> !o_master_system_reset)
		else $error("clock monitor on during reset");
	rsvd_zero_a: assert property (rd0_s |-> o_wb_dat[11] == 1'b0
		&& o_wb_dat[31:16] == 16'h0000)
		else $error("unimplemented bits read nonzero");
	sbor_fuse_a: assert property (
		rd0_s ##0 (i_brownout_enable_fuses != 2'h1) |-> !o_wb_dat[13])
		else $error("soft brownout bit visible");
	wdt_fuse_a: assert property (
		i_watchdog_enable_fuse && $past(i_watchdog_enable_fuse)
		|-> o_watchdog_en)
		else $error("fuse did not force watchdog");
	osc_hold_a: assert property (
		!o_master_system_reset && i_master_clear_pin
		&& i_clk_switch_enable
		|=> o_osc_select == i_current_oscillator_field)
		else $error("pin reset did not keep running clock");
	unmap_zero_a: assert property (
		o_wb_ack && !i_wb_we && i_wb_adr == 8'h0C |-> o_wb_dat == 0)
		else $error("unmapped read nonzero");
endmodule

bind rsc_reset_source_combiner rsc_checker u_chk (
	.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_wb_cyc(i_wb_cyc),
	.i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
	.o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
	.i_master_clear_pin(i_master_clear_pin),
	.i_brownout_enable_fuses(i_brownout_enable_fuses),
	.i_watchdog_enable_fuse(i_watchdog_enable_fuse),
	.i_clk_switch_enable(i_clk_switch_enable),
	.i_current_oscillator_field(i_current_oscillator_field),
	.o_osc_select(o_osc_select),
	.o_master_system_reset(o_master_system_reset),
	.o_cpu_run(o_cpu_run),
	.o_clock_fail_monitor_en(o_clock_fail_monitor_en),
	.o_watchdog_en(o_watchdog_en));

// ===== verif/rsc_osc_model.sv
// Purpose: oscillator and pll stand-in for the combiner
// Assumes: one tick every second core clock
// Notes:   lock comes 63 cycles after power-on release
`timescale 1ns/100ps

module rsc_osc_model (
	input  wire logic i_core_clk,
	input  wire logic i_nrst,
	output logic      o_osc_tick,
	output logic      o_pll_lock
);
	logic       tick_ff;
	logic [5:0] lock_ff;

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			tick_ff <= 1'b0;
			lock_ff <= 6'h00;
		end else begin
			tick_ff <= ~tick_ff;
			if (lock_ff != 6'h3F)
				lock_ff <= lock_ff + 6'h01;
		end
	end
	assign o_osc_tick = tick_ff;
	assign o_pll_lock = (lock_ff == 6'h3F);
endmodule

// ===== verif/rsc_reset_source_combiner_bench.sv
// Purpose: self-checking bench of the reset source combiner
// Assumes: short por and power-up counts
// Notes:   fuses pick clock 5, running clock field is 2
`timescale 1ns/100ps

module rsc_reset_source_combiner_bench;
	import rsc_pkg::*;
	localparam int POR_N = 20;
	localparam int PWR_N = 50;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [3:0]  sel = 4'hF;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [11:0] ev = 12'h000;
	logic [1:0]  fuses = 2'h3;
	logic        wfuse = 1'b0;
	logic        xtal = 1'b1;
	logic        pllu = 1'b1;
	logic        tspd = 1'b0;
	logic [31:0] rdat, q;
	logic        ack, msr, run, clock_fail_monitor, brownout_enable_fuses, wdten, ret, pms, tick, lock;
	logic [2:0]  osc;
	int          failures = 0;
	int          checks_done = 0;
	int          t;
	// source mask, expected cause, expected clock select
	logic [30:0] evt [12] = '{
		{12'h001, 16'h0080, 3'h2}, {12'h002, 16'h0040, 3'h2},
		{12'h004, 16'h8000, 3'h2}, {12'h008, 16'h4000, 3'h2},
		{12'h010, 16'h4000, 3'h2}, {12'h020, 16'h0200, 3'h2},
		{12'h040, 16'h0010, 3'h2}, {12'h080, 16'h0008, 3'h2},
		{12'h100, 16'h0004, 3'h2}, {12'h880, 16'h0408, 3'h2},
		{12'h200, 16'h0002, 3'h5}, {12'h400, 16'h0003, 3'h5}};
	// fuses, write data, read back, {retention, progmem, watchdog}
	logic [36:0] rw [3] = '{{2'h1, 16'hFFFF, 16'hF7FF, 3'h7},
		{2'h0, 16'hFFFF, 16'hD7FF, 3'h7}, {2'h1, 16'h0, 16'h0, 3'h0}};

	always #5 clk = ~clk;

	rsc_reset_source_combiner #(.POR_CYCLES(POR_N), .POWER_UP_TIMER_CYCLES(PWR_N),
		.CLOCK_FAIL_MONITOR_CYCLES(5)) u_dut (
		.i_core_clk(clk), .i_nrst(nrst), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
		.o_wb_dat(rdat), .o_wb_ack(ack), .i_master_clear_pin(ev[0]),
		.i_reset_instr(ev[1]), .i_trap_conflict(ev[2]),
		.i_illegal_op(ev[3]), .i_uninit_pointer_reset(ev[4]),
		.i_config_mismatch(ev[5]), .i_watchdog_reset(ev[6]),
		.i_sleep_instr(ev[7]), .i_idle_instr(ev[8]),
		.i_brownout_det(ev[9]), .i_deep_sleep_wake(ev[10]),
		.i_deep_sleep_enable(ev[11]), .i_brownout_enable_fuses(fuses),
		.i_watchdog_enable_fuse(wfuse), .i_power_up_timer_enable_fuse(1'b1),
		.i_clk_switch_enable(1'b1), .i_two_speed_enable(tspd),
		.i_oscillator_fuse_select(3'h5), .i_current_oscillator_field(3'h2),
		.i_osc_is_crystal(xtal), .i_osc_tick(tick), .i_pll_used(pllu),
		.i_pll_lock(lock), .o_master_system_reset(msr), .o_cpu_run(run),
		.o_osc_select(osc), .o_clock_fail_monitor_en(clock_fail_monitor),
		.o_brownout_en(brownout_enable_fuses), .o_watchdog_en(wdten),
		.o_retention_regulator_select(ret), .o_progmem_sleep_power(pms));

	rsc_osc_model u_osc (.i_core_clk(clk), .i_nrst(nrst),
		.o_osc_tick(tick), .o_pll_lock(lock));

	task automatic close_out;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		{cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat;
		if (n >= 20) begin
			chk("ack", 1, 0);
			close_out;
		end
		{cyc, stb} <= 2'b00;
	endtask

	task automatic fire(input logic [11:0] s);
		@(posedge clk);
		ev <= s;
		@(posedge clk);
		ev <= 12'h000;
		repeat (4) @(posedge clk);
		for (t = 0; msr !== 1'b0 && t < 300; t++)
			@(posedge clk);
		chk("release", 0, msr);
	endtask

	initial begin
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		for (t = 0; msr !== 1'b0 && t < 500; t++)
			@(posedge clk);
		chk("rel_min", 1, t >= POR_N + PWR_N);
		chk("rel_max", 1, t <= POR_N + PWR_N + 8);
		for (; run !== 1'b1 && t < 5000; t++)
			@(posedge clk);
		chk("ost_wait", 1, t >= 2 * OST_PERIODS && run);
		chk("osc_por", 3'h5, osc);
		chk("clock_fail_monitor_on", 1, clock_fail_monitor);
		xtal <= 1'b0;
		pllu <= 1'b0;
		wb(1'b0, RSC_ADDR_CAUSE, 0);
		chk("por_cause", 32'h3, q);
		for (int i = 0; i < 3; i++) begin
			fuses <= rw[i][36:35];
			wb(1'b1, RSC_ADDR_CAUSE, rw[i][34:19]);
			chk("no_reset", 0, msr);
			wb(1'b0, RSC_ADDR_CAUSE, 0);
			chk("cause_rw", rw[i][18:3], q);
			chk("ctl", rw[i][2:0], {ret, pms, wdten});
		end
		fuses <= 2'h3;
		for (int i = 0; i < 12; i++) begin
			wb(1'b1, RSC_ADDR_CAUSE, 0);
			fire(evt[i][30:19]);
			wb(1'b0, RSC_ADDR_CAUSE, 0);
			chk("cause_ev", evt[i][18:3], q);
			chk("osc_ev", evt[i][2:0], osc);
		end
		wb(1'b1, RSC_ADDR_CAUSE, 32'h10);
		fire(12'h100);
		wb(1'b0, RSC_ADDR_CAUSE, 0);
		chk("watchdog_timeout_flag_clear", 32'h4, q);
		wb(1'b1, 8'h0C, 32'hFFFF);
		wb(1'b0, 8'h0C, 0);
		chk("unmapped", 0, q);
		wb(1'b0, RSC_ADDR_CAUSE, 0);
		chk("unmapped_wr", 32'h4, q);
		wfuse <= 1'b1;
		repeat (3) @(posedge clk);
		chk("wdt_fuse", 1, wdten);
		chk("brownout_enable_fuses_fuse", 1, brownout_enable_fuses);
		tspd <= 1'b1;
		fire(12'h200);
		chk("osc_2spd", OSC_FRC, osc);
		close_out;
	end

	initial begin
		repeat (20000) @(posedge clk);
		chk("timeout", 0, 1);
		close_out;
	end
endmodule
